//--- hdl/prc_pkg.sv
// shared constants and types for the reset / power control block and its management host
package prc_pkg;
  // register map (5-bit management register index)
  localparam logic [4:0]  REG_BASIC_MODE_CONTROL         = 5'h00;
  localparam logic [4:0]  REG_STATUS       = 5'h01;
  localparam logic [4:0]  REG_TRANSCEIVER_CONFIG_REGISTER        = 5'h10;
  localparam logic [4:0]  REG_CTRL         = 5'h1F;
  // basic_mode_control fields
  localparam int          BASIC_MODE_CONTROL_RESET       = 15;
  localparam int          BASIC_MODE_CONTROL_LOOP        = 14;
  localparam int          BASIC_MODE_CONTROL_SPD_LSB     = 13;
  localparam int          BASIC_MODE_CONTROL_ANEG        = 12;
  localparam int          BASIC_MODE_CONTROL_PDN         = 11;
  localparam int          BASIC_MODE_CONTROL_DUPLEX      = 8;
  localparam int          BASIC_MODE_CONTROL_SPD_MSB     = 6;
  localparam logic        BASIC_MODE_CONTROL_SPD_MSB_RST = 1'h1;
  // transceiver_config_register fields
  localparam int          TRANSCEIVER_CONFIG_REGISTER_DEEP       = 7;
  localparam int          TRANSCEIVER_CONFIG_REGISTER_SLEEP_HI   = 9;
  localparam int          TRANSCEIVER_CONFIG_REGISTER_SLEEP_LO   = 8;
  localparam logic [1:0]  SLEEP_ACTIVE     = 2'h2;
  localparam logic [1:0]  SLEEP_PASSIVE    = 2'h3;
  // global control and status fields
  localparam int          CTRL_GRESET      = 15;
  localparam int          CTRL_RESTART     = 14;
  localparam int          STATUS_PARTNER   = 4;
  // forced speed codes {msb,lsb}
  localparam logic [1:0]  SPEED_RESERVED   = 2'h3;
  localparam logic [1:0]  SPEED_10         = 2'h0;
  // station address
  localparam logic [4:0]  ADDR_DEFAULT     = 5'h00;
  localparam logic [4:0]  ADDR_MASK_SMALL  = 5'h0F;
  localparam logic [4:0]  ADDR_MASK_LARGE  = 5'h1F;
  // management frame
  localparam logic [1:0]  OP_WRITE         = 2'h1;
  localparam logic [1:0]  OP_READ          = 2'h2;
  localparam logic [1:0]  FRAME_START      = 2'h1;
  localparam logic [1:0]  FRAME_TA         = 2'h2;
  localparam logic [5:0]  PREAMBLE_LEN     = 6'h20;
  localparam logic [5:0]  HDR_LAST         = 6'h0C;
  localparam logic [5:0]  TA_LAST          = 6'h01;
  localparam logic [5:0]  DATA_LAST        = 6'h0F;
  localparam logic [5:0]  HOST_TA_BIT      = 6'h2E;
  localparam logic [5:0]  HOST_DATA_BIT    = 6'h30;
  localparam logic [5:0]  HOST_LAST_BIT    = 6'h3F;
  // timing
  localparam int          CLK_PERIOD_NS    = 20;
  localparam int          HW_RESET_MIN_NS  = 1000;
  localparam int          HW_RESET_CYC     = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          LOOP_DEAD_US     = 500;
  localparam int          LOOP_DEAD_CYC    = LOOP_DEAD_US * 1000 / CLK_PERIOD_NS;
  localparam int          DEAD_W           = 15;
  localparam logic [4:0]  POR_CYC          = 5'h10;
  localparam logic [3:0]  SOFT_RST_CYC     = 4'h8;
  localparam logic [4:0]  MDC_HALF_CYC     = 5'h0A;
  localparam logic [4:0]  MDC_LAST_CYC     = 5'h13;

  typedef enum logic [1:0] {
    MS_PRE  = 2'b00,
    MS_HDR  = 2'b01,
    MS_TA   = 2'b10,
    MS_DATA = 2'b11
  } prc_mdio_st_t;

  typedef enum logic [0:0] {
    HS_IDLE = 1'b0,
    HS_RUN  = 1'b1
  } prc_host_st_t;
endpackage : prc_pkg

//--- hdl/prc_if.sv
// management bus and reset / power-down pins between the host and the transceiver
`timescale 1ns/1ps
interface prc_if;
  logic mdc;
  logic host_mdio_o;
  logic host_mdio_oe;
  logic dev_mdio_o;
  logic dev_mdio_oe;
  logic mdio;
  logic hw_reset_n;
  logic shared_power_down_pin_n;

  // open line idles high through the pull-up
  assign mdio = host_mdio_oe ? host_mdio_o : (dev_mdio_oe ? dev_mdio_o : 1'b1);

  modport host (
    output mdc,
    output host_mdio_o,
    output host_mdio_oe,
    output hw_reset_n,
    output shared_power_down_pin_n,
    input  mdio
  );

  modport device (
    input  mdc,
    input  mdio,
    input  hw_reset_n,
    input  shared_power_down_pin_n,
    output dev_mdio_o,
    output dev_mdio_oe
  );
endinterface : prc_if

//--- hdl/prc_device.sv
// transceiver end: strap capture, resets, power saving and basic mode control with management slave
`timescale 1ns/1ps

module prc_device
  import prc_pkg::*;
#(
  parameter int   LOOPBACK_DEAD_CYC = LOOP_DEAD_CYC,
  parameter logic SMALL_PACKAGE     = 1'b0
) (
  input  wire logic       clk_i,                   // 50 MHz device clock
  input  wire logic       reset_i,                 // sync active-high supply reset
  prc_if.device           bus,                     // management bus and pins
  input  wire logic [4:0] strapped_station_address_i, // address strap levels
  input  wire logic       strap_aneg_i,            // autoneg enable strap
  input  wire logic       strap_duplex_i,          // full duplex strap
  input  wire logic       link_partner_detect_i,   // partner energy seen
  output logic      [4:0] station_address_o,       // latched address
  output logic            circuit_reset_o,         // transceiver circuits held in reset
  output logic            power_down_o,            // transceiver powered down
  output logic            crystal_input_pad_off_o, // crystal pad switched off
  output logic            sleep_o,                 // sleep power state
  output logic            nlp_send_o,              // link pulses sent
  output logic            loopback_o,              // transmit looped to receive
  output logic            rx_data_valid_o,         // receive path usable
  output logic            autoneg_en_o,            // auto-negotiation enabled
  output logic      [1:0] speed_o,                 // forced speed {msb,lsb}
  output logic            full_duplex_o            // forced duplex
);

  typedef struct packed {
    logic [4:0]        addr;
    logic              strap_aneg;
    logic              strap_dup;
    logic [4:0]        por_cnt;
    logic [3:0]        rst_cnt;
    logic [3:0]        g_cnt;
    logic              greset;
    logic              restart;
    logic              loop;
    logic              spd_lsb;
    logic              aneg;
    logic              pdn;
    logic              dup;
    logic              spd_msb;
    logic [1:0]        sleep_mode;
    logic              deep;
    logic              partner_lat;
    logic [1:0]        speed;
    logic [DEAD_W-1:0] dead_cnt;
    logic              rx_ok;
    prc_mdio_st_t      st;
    logic [5:0]        cnt;
    logic [12:0]       hdr;
    logic [15:0]       sh;
    logic              rd;
    logic              mdc_q;
    logic              mdio_o;
    logic              mdio_oe;
  } prc_dev_state_t;

  prc_dev_state_t r;
  prc_dev_state_t n;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic prc_dev_state_t ieee_defaults(input prc_dev_state_t s);
    prc_dev_state_t t;
    t             = s;
    t.loop        = 1'b0;
    t.spd_lsb     = 1'b0;
    t.aneg        = s.strap_aneg;
    t.pdn         = 1'b0;
    t.dup         = s.strap_dup;
    t.spd_msb     = BASIC_MODE_CONTROL_SPD_MSB_RST;
    t.partner_lat = 1'b0;
    return t;
  endfunction : ieee_defaults

  function automatic prc_dev_state_t all_defaults(input prc_dev_state_t s);
    prc_dev_state_t t;
    t            = ieee_defaults(s);
    t.sleep_mode = 2'h0;
    t.deep       = 1'b0;
    return t;
  endfunction : all_defaults

  function automatic logic [15:0] read_word(input prc_dev_state_t s, input logic [4:0] ra);
    logic [15:0] w;
    w = 16'h0000;
    case (ra)
      REG_BASIC_MODE_CONTROL: begin
        w[BASIC_MODE_CONTROL_RESET]   = (s.rst_cnt != 4'h0);
        w[BASIC_MODE_CONTROL_LOOP]    = s.loop;
        w[BASIC_MODE_CONTROL_SPD_LSB] = s.spd_lsb;
        w[BASIC_MODE_CONTROL_ANEG]    = s.aneg;
        w[BASIC_MODE_CONTROL_PDN]     = s.pdn;
        w[BASIC_MODE_CONTROL_DUPLEX]  = s.dup;
        w[BASIC_MODE_CONTROL_SPD_MSB] = s.spd_msb;
      end
      REG_STATUS: w[STATUS_PARTNER] = s.partner_lat;
      REG_TRANSCEIVER_CONFIG_REGISTER: begin
        w[TRANSCEIVER_CONFIG_REGISTER_SLEEP_HI:TRANSCEIVER_CONFIG_REGISTER_SLEEP_LO] = s.sleep_mode;
        w[TRANSCEIVER_CONFIG_REGISTER_DEEP]                    = s.deep;
      end
      REG_CTRL: begin
        w[CTRL_GRESET]  = s.greset;
        w[CTRL_RESTART] = s.restart;
      end
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic        rise;
  logic        fall;
  logic        wr;
  logic        rd_clr;
  logic [15:0] wdata;
  logic [12:0] hd;
  logic [4:0]  my_addr;

  always_comb begin
    n       = r;
    wr      = 1'b0;
    rd_clr  = 1'b0;
    wdata   = {r.sh[14:0], bus.mdio};
    hd      = {r.hdr[11:0], bus.mdio};
    my_addr = r.addr & (SMALL_PACKAGE ? ADDR_MASK_SMALL : ADDR_MASK_LARGE);
    rise    = bus.mdc & ~r.mdc_q;
    fall    = ~bus.mdc & r.mdc_q;
    n.mdc_q = bus.mdc;
    if (reset_i || !bus.hw_reset_n) begin
      // power-on and pin reset: hold defaults, straps latched while counting
      n         = all_defaults(r);
      n.addr    = ADDR_DEFAULT;
      n.por_cnt = POR_CYC;
      n.rst_cnt = 4'h0;
      n.g_cnt   = 4'h0;
      n.greset  = 1'b0;
      n.restart = 1'b0;
      n.st      = MS_PRE;
      n.cnt     = 6'h00;
      n.mdio_oe = 1'b0;
      n.mdio_o  = 1'b1;
      n.mdc_q   = 1'b0;
      n.dead_cnt = '0;
      n.rx_ok   = 1'b0;
      n.speed   = SPEED_10;
    end else if (r.por_cnt != 5'h00) begin
      n.addr       = strapped_station_address_i;
      n.strap_aneg = strap_aneg_i;
      n.strap_dup  = strap_duplex_i;
      n            = all_defaults(n);
      n.por_cnt    = r.por_cnt - 5'h01;
    end else begin
      // management slave keeps running in every power state
      case (r.st)
        MS_PRE: begin
          if (rise) begin
            if (bus.mdio) begin
              n.cnt = (r.cnt == PREAMBLE_LEN) ? r.cnt : r.cnt + 6'h01;
            end else if (r.cnt == PREAMBLE_LEN) begin
              n.st  = MS_HDR;
              n.cnt = 6'h00;
            end else begin
              n.cnt = 6'h00;
            end
          end
        end
        MS_HDR: begin
          if (rise) begin
            n.hdr = hd;
            n.cnt = r.cnt + 6'h01;
            if (r.cnt == HDR_LAST) begin
              n.cnt = 6'h00;
              n.rd  = (hd[11:10] == OP_READ);
              if (hd[12] && hd[9:5] == my_addr && (hd[11:10] == OP_READ || hd[11:10] == OP_WRITE)) begin
                n.st = MS_TA;
                if (hd[11:10] == OP_READ) begin
                  n.sh   = read_word(r, hd[4:0]);
                  rd_clr = (hd[4:0] == REG_STATUS);
                end
              end else begin
                n.st = MS_PRE;
              end
            end
          end
        end
        MS_TA: begin
          if (rise) begin
            n.cnt = r.cnt + 6'h01;
            if (r.cnt == TA_LAST) begin
              n.st  = MS_DATA;
              n.cnt = 6'h00;
            end
          end
          if (fall && r.rd && r.cnt == TA_LAST) begin
            n.mdio_oe = 1'b1;
            n.mdio_o  = 1'b0;
          end
        end
        MS_DATA: begin
          if (rise) begin
            n.cnt = r.cnt + 6'h01;
            if (!r.rd) begin
              n.sh = wdata;
            end
            if (r.cnt == DATA_LAST) begin
              n.st      = MS_PRE;
              n.cnt     = 6'h00;
              n.mdio_oe = 1'b0;
              wr        = !r.rd;
            end
          end
          if (fall && r.rd) begin
            n.mdio_o = r.sh[15];
            n.sh     = {r.sh[14:0], 1'b0};
          end
        end
        default: n.st = MS_PRE;
      endcase

      // self-clearing reset counters
      if (r.rst_cnt != 4'h0) begin
        n.rst_cnt = r.rst_cnt - 4'h1;
      end
      if (r.g_cnt != 4'h0) begin
        n.g_cnt = r.g_cnt - 4'h1;
      end else begin
        n.greset  = 1'b0;
        n.restart = 1'b0;
      end

      // register writes
      if (wr) begin
        case (r.hdr[4:0])
          REG_BASIC_MODE_CONTROL: begin
            if (wdata[BASIC_MODE_CONTROL_RESET]) begin
              // standard registers only; autoneg/duplex straps sampled again
              n.strap_aneg = strap_aneg_i;
              n.strap_dup  = strap_duplex_i;
              n            = ieee_defaults(n);
              n.rst_cnt    = SOFT_RST_CYC;
            end else begin
              n.loop    = wdata[BASIC_MODE_CONTROL_LOOP];
              n.spd_lsb = wdata[BASIC_MODE_CONTROL_SPD_LSB];
              n.aneg    = wdata[BASIC_MODE_CONTROL_ANEG];
              n.pdn     = wdata[BASIC_MODE_CONTROL_PDN];
              n.dup     = wdata[BASIC_MODE_CONTROL_DUPLEX];
              n.spd_msb = wdata[BASIC_MODE_CONTROL_SPD_MSB];
            end
          end
          REG_TRANSCEIVER_CONFIG_REGISTER: begin
            n.sleep_mode = wdata[TRANSCEIVER_CONFIG_REGISTER_SLEEP_HI:TRANSCEIVER_CONFIG_REGISTER_SLEEP_LO];
            n.deep       = wdata[TRANSCEIVER_CONFIG_REGISTER_DEEP];
          end
          REG_CTRL: begin
            if (wdata[CTRL_GRESET]) begin
              n         = all_defaults(n);
              n.greset  = 1'b1;
              n.g_cnt   = SOFT_RST_CYC;
            end else if (wdata[CTRL_RESTART]) begin
              n.restart = 1'b1;
              n.g_cnt   = SOFT_RST_CYC;
            end
          end
          default: n.sh = r.sh;
        endcase
      end

      // pin wins over any write or soft reset in the same cycle
      if (!bus.shared_power_down_pin_n) begin
        n.pdn = 1'b1;
      end

      // partner flag: set wins over clear-on-read
      if (rd_clr) begin
        n.partner_lat = 1'b0;
      end
      if (link_partner_detect_i) begin
        n.partner_lat = 1'b1;
      end

      // reserved speed code keeps the last legal speed
      if (!r.aneg && {r.spd_msb, r.spd_lsb} != SPEED_RESERVED) begin
        n.speed = {r.spd_msb, r.spd_lsb};
      end

      // receive path blanked after loopback is switched on
      if (!r.loop) begin
        n.dead_cnt = '0;
        n.rx_ok    = 1'b0;
      end else if (r.dead_cnt == DEAD_W'(LOOPBACK_DEAD_CYC - 1)) begin
        n.rx_ok = 1'b1;
      end else begin
        n.dead_cnt = r.dead_cnt + DEAD_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    r <= n;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic sleeping;

  // sleep ends by itself once a partner shows up
  assign sleeping                = r.sleep_mode[1] && !link_partner_detect_i && !r.pdn;
  assign station_address_o       = r.addr & (SMALL_PACKAGE ? ADDR_MASK_SMALL : ADDR_MASK_LARGE);
  assign circuit_reset_o         = (r.por_cnt != 5'h00) || r.greset || r.restart;
  assign power_down_o            = r.pdn;
  assign crystal_input_pad_off_o = r.pdn && r.deep;
  assign sleep_o                 = sleeping;
  assign nlp_send_o              = !r.pdn && !(sleeping && r.sleep_mode == SLEEP_PASSIVE);
  assign loopback_o              = r.loop;
  assign rx_data_valid_o         = !r.loop || r.rx_ok;
  assign autoneg_en_o            = r.aneg;
  assign speed_o                 = r.speed;
  assign full_duplex_o           = r.dup;
  assign bus.dev_mdio_o          = r.mdio_o;
  assign bus.dev_mdio_oe         = r.mdio_oe;
endmodule : prc_device

//--- hdl/prc_host.sv
// station management end: frames register accesses on the serial bus and drives reset / power-down pins
`timescale 1ns/1ps
module prc_host
  import prc_pkg::*;
(
  input  wire logic        clk_i,            // 50 MHz clock
  input  wire logic        reset_i,          // sync active-high reset
  prc_if.host              bus,              // management bus and pins
  input  wire logic        cmd_valid_i,      // access request
  input  wire logic        cmd_write_i,      // 1 write, 0 read
  input  wire logic [4:0]  cmd_phy_i,        // target station address
  input  wire logic [4:0]  cmd_reg_i,        // register index
  input  wire logic [15:0] cmd_wdata_i,      // write data
  output logic             cmd_ready_o,      // request accepted when valid
  output logic             rsp_valid_o,      // access finished, one cycle
  output logic      [15:0] rsp_rdata_o,      // read data
  input  wire logic        hw_reset_req_i,   // start a reset pulse
  input  wire logic        power_down_req_i  // hold power-down pin asserted
);

  typedef struct packed {
    prc_host_st_t st;
    logic [4:0]   div;
    logic [5:0]   bitn;
    logic [63:0]  frame;
    logic         is_rd;
    logic [15:0]  rdata;
    logic         mdc;
    logic         mdio_o;
    logic         mdio_oe;
    logic         rsp;
    logic [5:0]   hwr_cnt;
  } prc_host_state_t;

  prc_host_state_t r;
  prc_host_state_t n;

  always_comb begin
    n     = r;
    n.rsp = 1'b0;
    if (reset_i) begin
      n.st      = HS_IDLE;
      n.div     = 5'h00;
      n.bitn    = 6'h00;
      n.frame   = 64'h0;
      n.is_rd   = 1'b0;
      n.rdata   = 16'h0000;
      n.mdc     = 1'b0;
      n.mdio_o  = 1'b1;
      n.mdio_oe = 1'b0;
      n.hwr_cnt = 6'h00;
    end else begin
      // pin pulse at least the documented minimum
      if (r.hwr_cnt != 6'h00) begin
        n.hwr_cnt = r.hwr_cnt - 6'h01;
      end else if (hw_reset_req_i && r.st == HS_IDLE) begin
        n.hwr_cnt = 6'(HW_RESET_CYC);
      end
      case (r.st)
        HS_IDLE: begin
          // last high phase of a frame ends here, so it keeps its full length
          n.mdc = 1'b0;
          if (cmd_valid_i && cmd_ready_o) begin
            n.st    = HS_RUN;
            n.div   = 5'h00;
            n.bitn  = 6'h00;
            n.is_rd = !cmd_write_i;
            n.frame = {{32{1'b1}}, FRAME_START, cmd_write_i ? OP_WRITE : OP_READ,
                       cmd_phy_i, cmd_reg_i, FRAME_TA, cmd_write_i ? cmd_wdata_i : 16'hFFFF};
          end
        end
        HS_RUN: begin
          n.div = r.div + 5'h01;
          if (r.div == 5'h00) begin
            n.mdc     = 1'b0;
            n.mdio_oe = !r.is_rd || r.bitn < HOST_TA_BIT;
            n.mdio_o  = r.frame[63];
          end
          if (r.div == MDC_HALF_CYC) begin
            n.mdc = 1'b1;
            if (r.is_rd && r.bitn >= HOST_DATA_BIT) begin
              n.rdata = {r.rdata[14:0], bus.mdio};
            end
          end
          if (r.div == MDC_LAST_CYC) begin
            n.div   = 5'h00;
            n.frame = {r.frame[62:0], 1'b1};
            n.bitn  = r.bitn + 6'h01;
            if (r.bitn == HOST_LAST_BIT) begin
              n.st      = HS_IDLE;
              n.mdio_oe = 1'b0;
              n.rsp     = 1'b1;
            end
          end
        end
        default: n.st = HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    r <= n;
  end

  // no new access while a reset pulse is on the pin or about to start
  assign cmd_ready_o                 = (r.st == HS_IDLE) && (r.hwr_cnt == 6'h00) && !reset_i && !hw_reset_req_i;
  assign rsp_valid_o                 = r.rsp;
  assign rsp_rdata_o                 = r.rdata;
  assign bus.mdc                     = r.mdc;
  assign bus.host_mdio_o             = r.mdio_o;
  assign bus.host_mdio_oe            = r.mdio_oe;
  assign bus.hw_reset_n              = (r.hwr_cnt == 6'h00);
  // pin follows the request directly so it is released as soon as asked
  assign bus.shared_power_down_pin_n = !power_down_req_i;
endmodule : prc_host

//--- verification/prc_monitor.sv
// checker watching the management bus and reset pin between the two ends
`timescale 1ns/1ps
module prc_monitor (
  input wire logic clk_i,                    // clock
  input wire logic reset_i,                  // sync reset
  input wire logic mdc,                      // management clock
  input wire logic host_mdio_o,              // host drive value
  input wire logic host_mdio_oe,             // host drive enable
  input wire logic dev_mdio_o,               // device drive value
  input wire logic dev_mdio_oe,              // device drive enable
  input wire logic mdio,                     // resolved line
  input wire logic hw_reset_n,               // reset pin
  input wire logic shared_power_down_pin_n   // power-down pin
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [7:0] low_r;
  // saturating count of low reset-pin cycles
  always_ff @(posedge clk_i) begin
    if (reset_i || hw_reset_n) low_r <= 8'h00;
    else if (low_r != 8'hFF) low_r <= low_r + 8'h01;
  end
  sequence s_hi10; mdc [*8] ##1 mdc ##1 mdc; endsequence
  sequence s_lo10; !mdc [*8] ##1 !mdc ##1 !mdc; endsequence
  property p_rst_len; $rose(hw_reset_n) |-> low_r >= 8'h32; endproperty
  property p_rst_quiet; !hw_reset_n |-> !mdc; endproperty
  property p_no_clash; !(host_mdio_oe && dev_mdio_oe); endproperty
  property p_mdc_hi; $rose(mdc) |-> s_hi10 ##1 !mdc; endproperty
  property p_mdc_lo; $fell(mdc) |-> s_lo10; endproperty
  property p_dev_start; $rose(dev_mdio_oe) |-> !mdc && !dev_mdio_o; endproperty
  property p_dev_stable; mdc && $past(mdc) && dev_mdio_oe |-> $stable(dev_mdio_o); endproperty
  property p_host_stable; mdc && $past(mdc) |-> $stable(host_mdio_o); endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse too short");
  a_rst_quiet: assert property (p_rst_quiet) else $error("clock during reset");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive");
  a_mdc_hi: assert property (p_mdc_hi) else $error("bad high phase");
  a_mdc_lo: assert property (p_mdc_lo) else $error("bad low phase");
  a_dev_start: assert property (p_dev_start) else $error("bad turnaround");
  a_dev_stable: assert property (p_dev_stable) else $error("device data moved");
  a_host_stable: assert property (p_host_stable) else $error("host data moved");
endmodule : prc_monitor

//--- verification/tb_phy_reset_power_control.sv
// self-checking bench for the host and transceiver ends
`timescale 1ns/1ps
module tb_phy_reset_power_control;
  import prc_pkg::*;
  logic clk_i, reset_i, cv, cw, hrq, pdq, lpd, sdx, san, rdy, rsp;
  logic crst, pdn, xoff, slp, nlp, lb, rxv, an, fdx;
  logic [1:0] spd;
  logic [4:0] cr, phy, strap, addr;
  logic [15:0] cd, rd, rdt;
  int n_fail, check_count, cyc;
  prc_if bus ();
  prc_host i_prc_host (.clk_i(clk_i), .reset_i(reset_i), .bus(bus), .cmd_valid_i(cv), .cmd_write_i(cw),
    .cmd_phy_i(phy), .cmd_reg_i(cr), .cmd_wdata_i(cd), .cmd_ready_o(rdy), .rsp_valid_o(rsp),
    .rsp_rdata_o(rdt), .hw_reset_req_i(hrq), .power_down_req_i(pdq));
  // short dead time keeps the run brief
  prc_device #(.LOOPBACK_DEAD_CYC(40)) i_prc_device (.clk_i(clk_i), .reset_i(reset_i), .bus(bus),
    .strapped_station_address_i(strap), .strap_aneg_i(san), .strap_duplex_i(sdx),
    .link_partner_detect_i(lpd), .station_address_o(addr), .circuit_reset_o(crst), .power_down_o(pdn),
    .crystal_input_pad_off_o(xoff), .sleep_o(slp), .nlp_send_o(nlp), .loopback_o(lb),
    .rx_data_valid_o(rxv), .autoneg_en_o(an), .speed_o(spd), .full_duplex_o(fdx));
  prc_monitor i_prc_monitor (.clk_i(clk_i), .reset_i(reset_i), .mdc(bus.mdc), .host_mdio_o(bus.host_mdio_o),
    .host_mdio_oe(bus.host_mdio_oe), .dev_mdio_o(bus.dev_mdio_o), .dev_mdio_oe(bus.dev_mdio_oe),
    .mdio(bus.mdio), .hw_reset_n(bus.hw_reset_n), .shared_power_down_pin_n(bus.shared_power_down_pin_n));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // one whole frame; waits for the host's completion pulse
  task automatic acc(input logic w, input logic [4:0] r, input logic [15:0] d);
    @(posedge clk_i);
    cv <= 1'b1;
    cw <= w;
    cr <= r;
    cd <= d;
    do @(posedge clk_i); while (rdy !== 1'b1);
    cv <= 1'b0;
    do @(posedge clk_i); while (rsp !== 1'b1);
    rd = rdt;
    repeat (2) @(posedge clk_i);
  endtask : acc
  task automatic t_strap();
    chk(addr, 16'h0000);
    acc(1'b0, 5'h00, 16'h0000);
    chk(rd, 16'h0140);
    acc(1'b1, 5'h00, 16'h2000);
    strap <= 5'h13;
    san <= 1'b1;
    hrq <= 1'b1;
    @(posedge clk_i);
    hrq <= 1'b0;
    repeat (60) @(posedge clk_i);
    chk(crst, 16'h0001);
    repeat (30) @(posedge clk_i);
    chk(crst, 16'h0000);
    chk(addr, 16'h0013);
    acc(1'b0, 5'h00, 16'h0000);
    chk(rd, 16'hFFFF);
    phy <= 5'h13;
    acc(1'b0, 5'h00, 16'h0000);
    chk(rd, 16'h1140);
  endtask : t_strap
  task automatic t_speed();
    logic [17:0] tbl [4];
    tbl = '{{16'h2000, 2'h1}, {16'h0040, 2'h2}, {16'h2040, 2'h2}, {16'h3000, 2'h2}};
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 5'h00, tbl[i][17:2]);
      chk(spd, tbl[i][1:0]);
    end
    chk(an, 16'h0001);
    acc(1'b1, 5'h00, 16'h4000);
    chk({lb, rxv}, 16'h0002);
    repeat (45) @(posedge clk_i);
    chk(rxv, 16'h0001);
  endtask : t_speed
  task automatic t_power();
    pdq <= 1'b1;
    acc(1'b1, 5'h00, 16'h0000);
    acc(1'b0, 5'h00, 16'h0000);
    chk(rd, 16'h0800);
    chk(pdn, 16'h0001);
    pdq <= 1'b0;
    acc(1'b1, 5'h10, 16'h0080);
    chk(xoff, 16'h0001);
    acc(1'b1, 5'h00, 16'h0000);
    chk({pdn, xoff}, 16'h0000);
    acc(1'b1, 5'h10, 16'h0200);
    chk({slp, nlp}, 16'h0003);
    lpd <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(slp, 16'h0000);
    lpd <= 1'b0;
    acc(1'b0, 5'h01, 16'h0000);
    chk(rd, 16'h0010);
    acc(1'b0, 5'h01, 16'h0000);
    chk(rd, 16'h0000);
    acc(1'b1, 5'h10, 16'h0300);
    chk({slp, nlp}, 16'h0002);
  endtask : t_power
  task automatic t_resets();
    sdx <= 1'b0;
    san <= 1'b0;
    acc(1'b1, 5'h00, 16'hC000);
    acc(1'b0, 5'h00, 16'h0000);
    chk(rd, 16'h0040);
    acc(1'b1, 5'h1F, 16'h4000);
    acc(1'b0, 5'h10, 16'h0000);
    chk(rd, 16'h0300);
    acc(1'b1, 5'h1F, 16'h8000);
    repeat (20) @(posedge clk_i);
    acc(1'b0, 5'h10, 16'h0000);
    chk(rd, 16'h0000);
    chk(addr, 16'h0013);
  endtask : t_resets
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    {reset_i, cv, cw, hrq, pdq, lpd, sdx, san} = 8'h82;
    {cr, phy, strap, cd} = 31'h0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    t_strap();
    t_speed();
    t_power();
    t_resets();
    conclude();
  end
endmodule : tb_phy_reset_power_control
